// >>> rtl/emce_consts.vh
// Constants for the EPROM memory command engine.
`ifndef EMCE_CONSTS_VH
`define EMCE_CONSTS_VH

// ==========================================================================
// Command codes
`define EMCE_CMD_READ_MEM 8'hf0
`define EMCE_CMD_READ_STATUS 8'haa
`define EMCE_CMD_READ_PAGE 8'hc3
`define EMCE_CMD_WRITE_MEM 8'h0f
`define EMCE_CMD_WRITE_STATUS 8'h55

// ==========================================================================
// Field geometry
`define EMCE_DATA_BYTES 16'h0080
`define EMCE_STATUS_BYTES 16'h0008
`define EMCE_DATA_AW 7
`define EMCE_STATUS_AW 3
`define EMCE_PAGE_LAST 5'h1f
`define EMCE_PAGE_HI 6
`define EMCE_PAGE_LO 5
`define EMCE_WP_BYTE 3'h0
`define EMCE_FACTORY_BYTE 3'h7

// ==========================================================================
// Reset contents
`define EMCE_ERASED 8'hff
`define EMCE_FACTORY_VAL 8'h00
`define EMCE_ONES 1'b1

// ==========================================================================
// CRC-8, polynomial x^8+x^5+x^4+1, reflected form for LSB-first shifting
`define EMCE_CRC_POLY 8'h8c
`define EMCE_CRC_INIT 8'h00

// ==========================================================================
// Slot counting
`define EMCE_BIT_LAST 3'h7
`define EMCE_BIT_ZERO 3'h0
`define EMCE_ADDR_ONE 16'h0001

`endif

// >>> rtl/emce_crc8.v
// Bit-serial CRC-8 accumulator with clear, preload and shift.
`include "emce_consts.vh"

module emce_crc8 (
  input wire clk,
  input wire rst,
  input wire clear,
  input wire load,
  input wire [7:0] load_val,
  input wire shift,
  input wire bit_in,
  output reg [7:0] crc_reg
);

  wire fb;
  reg [7:0] crc_next;

  // ========================================================================
  // Next value; clear and preload take priority over a shift
  assign fb = crc_reg[0] ^ bit_in;

  always @* begin
    crc_next = crc_reg;
    if (clear) begin
      crc_next = `EMCE_CRC_INIT;
    end else if (load) begin
      crc_next = load_val;
    end else if (shift) begin
      crc_next = {1'b0, crc_reg[7:1]} ^ (fb ? `EMCE_CRC_POLY : 8'h00);
    end
  end

  // ========================================================================
  // Accumulator
  always @(posedge clk) begin
    if (rst) begin
      crc_reg <= `EMCE_CRC_INIT;
    end else begin
      crc_reg <= crc_next;
    end
  end

endmodule // emce_crc8

// >>> rtl/emce_engine.v
// Memory-function command engine of an add-only EPROM slave.
`include "emce_consts.vh"

module emce_engine (
  input wire MCLK,
  input wire RESET,
  input wire BUS_RESET,
  input wire ROM_OK,
  input wire WR_STROBE,
  input wire WR_BIT,
  input wire RD_REQ,
  input wire PROG_PULSE,
  output reg RD_BIT,
  output reg RD_ACK,
  output wire BUSY
);

  // ========================================================================
  // States, one-hot
  localparam [10:0] S_IDLE = 11'h001;
  localparam [10:0] S_CMD = 11'h002;
  localparam [10:0] S_ADDR_LO = 11'h004;
  localparam [10:0] S_ADDR_HI = 11'h008;
  localparam [10:0] S_DATA = 11'h010;
  localparam [10:0] S_CRC = 11'h020;
  localparam [10:0] S_READ = 11'h040;
  localparam [10:0] S_ECRC = 11'h080;
  localparam [10:0] S_PROG = 11'h100;
  localparam [10:0] S_VERIFY = 11'h200;
  localparam [10:0] S_ONES = 11'h400;

  // ========================================================================
  // Command decode helpers
  function is_status;
    input [7:0] c;
    begin
      is_status = (c == `EMCE_CMD_READ_STATUS) ||
                  (c == `EMCE_CMD_WRITE_STATUS);
    end
  endfunction

  function is_write;
    input [7:0] c;
    begin
      is_write = (c == `EMCE_CMD_WRITE_MEM) ||
                 (c == `EMCE_CMD_WRITE_STATUS);
    end
  endfunction

  function is_known;
    input [7:0] c;
    begin
      is_known = (c == `EMCE_CMD_READ_MEM) ||
                 (c == `EMCE_CMD_READ_PAGE) ||
                 is_status(c) || is_write(c);
    end
  endfunction

  // ========================================================================
  // State and storage
  reg [10:0] state_reg;
  reg [10:0] state_next;
  reg [2:0] bit_reg;
  reg [7:0] cmd_reg;
  reg [7:0] shift_reg;
  reg [15:0] addr_reg;
  reg [7:0] data_reg;
  reg [7:0] data_mem [0:127];
  reg [7:0] status_mem [0:7];
  integer i;

  wire wr_ok;
  wire rd_ok;
  wire byte_done;
  wire [7:0] byte_in;
  wire [15:0] addr_inc;
  wire [15:0] limit;
  wire in_range;
  wire inc_in_range;
  wire [7:0] cur_byte;
  wire wp_bit;
  wire [7:0] crc_val;
  reg crc_clear;
  reg crc_load;
  reg crc_shift;
  reg crc_bit;
  reg out_bit;

  // ========================================================================
  // Slot qualification; writes only count in receiving states
  assign wr_ok = WR_STROBE && (state_reg == S_CMD || state_reg == S_ADDR_LO ||
                 state_reg == S_ADDR_HI || state_reg == S_DATA);
  assign rd_ok = RD_REQ && (state_reg == S_CRC || state_reg == S_READ ||
                 state_reg == S_ECRC || state_reg == S_VERIFY);
  assign byte_done = (wr_ok || rd_ok) && (bit_reg == `EMCE_BIT_LAST);
  assign byte_in = {WR_BIT, shift_reg[7:1]};
  assign addr_inc = addr_reg + `EMCE_ADDR_ONE;

  assign limit = is_status(cmd_reg) ? `EMCE_STATUS_BYTES : `EMCE_DATA_BYTES;
  assign in_range = addr_reg < limit;
  assign inc_in_range = addr_inc < limit;
  assign cur_byte = is_status(cmd_reg) ?
                    status_mem[addr_reg[`EMCE_STATUS_AW-1:0]] :
                    data_mem[addr_reg[`EMCE_DATA_AW-1:0]];
  // A cleared write-protect bit locks its page
  assign wp_bit = status_mem[`EMCE_WP_BYTE][addr_reg[`EMCE_PAGE_HI:
                                                    `EMCE_PAGE_LO]];
  assign BUSY = (state_reg != S_IDLE);

  // ========================================================================
  // CRC accumulator
  emce_crc8 u_crc (
    .clk(MCLK),
    .rst(RESET),
    .clear(crc_clear),
    .load(crc_load),
    .load_val(addr_inc[7:0]),
    .shift(crc_shift),
    .bit_in(crc_bit),
    .crc_reg(crc_val)
  );

  // ========================================================================
  // Bit source for read slots; idle and finished states answer ones
  always @* begin
    out_bit = `EMCE_ONES;
    case (state_reg)
      S_CRC, S_ECRC: out_bit = crc_val[bit_reg];
      S_READ, S_VERIFY: out_bit = cur_byte[bit_reg];
      default: out_bit = `EMCE_ONES;
    endcase
  end

  // ========================================================================
  // Sequencer and CRC control
  always @* begin
    state_next = state_reg;
    crc_clear = 1'b0;
    crc_load = 1'b0;
    crc_shift = 1'b0;
    crc_bit = WR_BIT;
    case (state_reg)
      S_IDLE: begin
        if (ROM_OK) begin
          crc_clear = 1'b1;
          state_next = S_CMD;
        end
      end
      S_CMD: begin
        crc_shift = wr_ok;
        if (byte_done) begin
          state_next = is_known(byte_in) ? S_ADDR_LO : S_ONES;
        end
      end
      S_ADDR_LO: begin
        crc_shift = wr_ok;
        if (byte_done) begin
          state_next = S_ADDR_HI;
        end
      end
      S_ADDR_HI: begin
        crc_shift = wr_ok;
        if (byte_done) begin
          // Writes collect a data byte first
          state_next = is_write(cmd_reg) ? S_DATA : S_CRC;
        end
      end
      S_DATA: begin
        crc_shift = wr_ok;
        if (byte_done) begin
          state_next = S_CRC;
        end
      end
      S_CRC: begin
        if (byte_done) begin
          if (is_write(cmd_reg)) begin
            state_next = S_PROG;
          end else begin
            // Data CRC starts from zero
            crc_clear = 1'b1;
            state_next = in_range ? S_READ : S_ONES;
          end
        end
      end
      S_READ: begin
        // Stream bytes, each bit into CRC
        crc_shift = rd_ok;
        crc_bit = out_bit;
        if (byte_done) begin
          // Page read breaks for a CRC at each page end
          if (!inc_in_range || (cmd_reg == `EMCE_CMD_READ_PAGE &&
              addr_reg[`EMCE_PAGE_LO-1:0] == `EMCE_PAGE_LAST)) begin
            state_next = S_ECRC;
          end
        end
      end
      S_ECRC: begin
        // End CRC; status CRC same path
        if (byte_done) begin
          if (cmd_reg == `EMCE_CMD_READ_PAGE && in_range) begin
            crc_clear = 1'b1;
            state_next = S_READ;
          end else begin
            state_next = S_ONES;
          end
        end
      end
      S_PROG: begin
        if (PROG_PULSE) begin
          state_next = S_VERIFY;
        end
      end
      S_VERIFY: begin
        if (byte_done) begin
          // Preload CRC with new address low byte
          crc_load = 1'b1;
          state_next = S_DATA;
        end
      end
      S_ONES: state_next = S_ONES;
      default: state_next = S_IDLE;
    endcase
  end

  // ========================================================================
  // State, counters and captured bytes
  always @(posedge MCLK) begin
    if (RESET) begin
      state_reg <= S_IDLE;
      bit_reg <= `EMCE_BIT_ZERO;
      cmd_reg <= 8'h00;
      shift_reg <= 8'h00;
      addr_reg <= 16'h0000;
      data_reg <= 8'h00;
    end else if (BUS_RESET) begin
      // Abort; no CRC on early end
      state_reg <= S_IDLE;
      bit_reg <= `EMCE_BIT_ZERO;
    end else begin
      state_reg <= state_next;
      if (wr_ok || rd_ok) begin
        bit_reg <= bit_reg + 3'h1;
      end
      if (wr_ok) begin
        shift_reg <= byte_in;
      end
      if (byte_done) begin
        case (state_reg)
          S_CMD: cmd_reg <= byte_in;
          S_ADDR_LO: addr_reg[7:0] <= byte_in;
          S_ADDR_HI: addr_reg[15:8] <= byte_in;
          S_DATA: data_reg <= byte_in;
          S_READ, S_VERIFY: addr_reg <= addr_inc;
          // Page read keeps the address, already stepped past the page just closed
          S_ECRC: addr_reg <= addr_reg;
          default: addr_reg <= addr_reg;
        endcase
      end
    end
  end

  // ========================================================================
  // EPROM arrays; contents only ever lose ones
  // Reset restores the erased image and the factory byte since there is no non-volatile cell
  always @(posedge MCLK) begin
    if (RESET) begin
      for (i = 0; i < `EMCE_DATA_BYTES; i = i + 1) begin
        data_mem[i] <= `EMCE_ERASED;
      end
      for (i = 0; i < `EMCE_STATUS_BYTES; i = i + 1) begin
        status_mem[i] <= `EMCE_ERASED;
      end
      status_mem[`EMCE_FACTORY_BYTE] <= `EMCE_FACTORY_VAL;
    end else if (!BUS_RESET && state_reg == S_PROG && PROG_PULSE &&
                 in_range) begin
      if (is_status(cmd_reg)) begin
        status_mem[addr_reg[`EMCE_STATUS_AW-1:0]] <=
          status_mem[addr_reg[`EMCE_STATUS_AW-1:0]] & data_reg;
      end else if (wp_bit) begin
        // Zeros in data clear bits; protect check
        data_mem[addr_reg[`EMCE_DATA_AW-1:0]] <=
          data_mem[addr_reg[`EMCE_DATA_AW-1:0]] & data_reg;
      end
    end
  end

  // ========================================================================
  // Read slot answer, one cycle after the request
  always @(posedge MCLK) begin
    if (RESET) begin
      RD_BIT <= `EMCE_ONES;
      RD_ACK <= 1'b0;
    end else begin
      RD_ACK <= RD_REQ;
      if (RD_REQ) begin
        // Verify byte comes from the array
        RD_BIT <= BUS_RESET ? `EMCE_ONES : out_bit;
      end
    end
  end

endmodule // emce_engine

// >>> testbench/emce_engine_props.sv
// Slot-interface properties of the memory command engine.
// ===========================================================
// Checker
module emce_engine_props (
  input wire MCLK,
  input wire RESET,
  input wire BUS_RESET,
  input wire ROM_OK,
  input wire WR_STROBE,
  input wire WR_BIT,
  input wire RD_REQ,
  input wire PROG_PULSE,
  input wire RD_BIT,
  input wire RD_ACK,
  input wire BUSY
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (RESET);

  // Idle read two edges after an abort, no selection in between
  sequence s_idle_read;
    BUS_RESET ##1 !ROM_OK ##1 (RD_REQ && !ROM_OK);
  endsequence
  // Slot answered by its acknowledge
  sequence s_slot;
    RD_REQ ##1 RD_ACK;
  endsequence

  a_ack_follows_req: assert property (RD_REQ |-> s_slot)
    else $error("read slot not acknowledged");
  a_ack_only_req: assert property (RD_ACK |-> $past(RD_REQ))
    else $error("acknowledge without slot");
  a_bit_stands: assert property (!RD_REQ |=> $stable(RD_BIT))
    else $error("answer bit moved");
  a_idle_on_abort: assert property (BUS_RESET |=> !BUSY)
    else $error("bus reset left engine busy");
  a_stay_idle: assert property (!BUSY && !ROM_OK |=> !BUSY)
    else $error("left idle without selection");
  a_rom_starts: assert property (!BUSY && ROM_OK && !BUS_RESET |=> BUSY)
    else $error("selection ignored");
  a_idle_ones: assert property (s_idle_read |=> RD_ACK && RD_BIT)
    else $error("aborted engine answered zero");
  a_ones_no_cmd: assert property (RD_REQ && !BUSY |=> RD_BIT)
    else $error("idle read answered zero");
endmodule // emce_engine_props

bind emce_engine emce_engine_props u_props (
  .MCLK(MCLK),
  .RESET(RESET),
  .BUS_RESET(BUS_RESET),
  .ROM_OK(ROM_OK),
  .WR_STROBE(WR_STROBE),
  .WR_BIT(WR_BIT),
  .RD_REQ(RD_REQ),
  .PROG_PULSE(PROG_PULSE),
  .RD_BIT(RD_BIT),
  .RD_ACK(RD_ACK),
  .BUSY(BUSY)
);

// >>> testbench/emce_bus_master.sv
// Bus master model driving the engine's slot layer.
// ===========================================================
// Master model
module emce_bus_master (
  input wire logic mclk,
  input wire logic rd_bit,
  input wire logic rd_ack,
  output logic rom_ok,
  output logic bus_reset,
  output logic wr_strobe,
  output logic wr_bit,
  output logic rd_req,
  output logic prog_pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  logic hang = 1'b0;

  // Everything quiet from time zero
  initial begin
    rom_ok = 1'b0;
    bus_reset = 1'b0;
    wr_strobe = 1'b0;
    wr_bit = 1'b0;
    rd_req = 1'b0;
    prog_pulse = 1'b0;
  end

  task automatic put(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      @(posedge mclk);
      wr_strobe <= 1'b1;
      wr_bit <= b[i];
    end
    @(posedge mclk);
    wr_strobe <= 1'b0;
    wr_bit <= ~b[7]; // Released line must not look valid
  endtask

  // Eight read slots; a missing answer marks the run as hung
  task automatic get(output logic [7:0] b);
    int n;
    b = 8'hxx;
    for (int i = 0; i < 8; i++) begin
      @(posedge mclk);
      rd_req <= 1'b1;
      @(posedge mclk);
      rd_req <= 1'b0;
      for (n = 0; n < 4 && !hang; n++) begin
        @(posedge mclk);
        if (rd_ack === 1'b1) break;
      end
      if (n == 4) hang = 1'b1;
      b[i] = rd_bit;
    end
  endtask

  // pulse only on a confirmed CRC
  task automatic pulse(input bit ok);
    if (ok) begin
      @(posedge mclk);
      prog_pulse <= 1'b1;
      @(posedge mclk);
      prog_pulse <= 1'b0;
    end
  endtask

  // Single-cycle pulse on one control line
  task automatic strobe(input bit sel);
    @(posedge mclk);
    if (sel) rom_ok <= 1'b1;
    else bus_reset <= 1'b1;
    @(posedge mclk);
    rom_ok <= 1'b0;
    bus_reset <= 1'b0;
  endtask
endmodule // emce_bus_master

// >>> testbench/emce_engine_tb.sv
// Self-checking bench for the memory command engine.
// ===========================================================
// Bench top
module emce_engine_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  wire bus_reset, rom_ok, wr_strobe, wr_bit, rd_req, prog_pulse;
  wire rd_bit, rd_ack, busy;
  int miscompares = 0;
  int comparisons = 0;
  logic [7:0] mem [0:127];
  logic [7:0] stat [0:7];

  initial forever #20 mclk = ~mclk;

  emce_engine dut (.MCLK(mclk), .RESET(reset), .BUS_RESET(bus_reset),
    .ROM_OK(rom_ok), .WR_STROBE(wr_strobe), .WR_BIT(wr_bit),
    .RD_REQ(rd_req), .PROG_PULSE(prog_pulse), .RD_BIT(rd_bit),
    .RD_ACK(rd_ack), .BUSY(busy));
  emce_bus_master m (.mclk(mclk), .rd_bit(rd_bit), .rd_ack(rd_ack),
    .rom_ok(rom_ok), .bus_reset(bus_reset), .wr_strobe(wr_strobe),
    .wr_bit(wr_bit), .rd_req(rd_req), .prog_pulse(prog_pulse));

  // Reference CRC, LSB first, reflected polynomial
  function automatic logic [7:0] crc8(logic [7:0] c, logic [7:0] b);
    for (int i = 0; i < 8; i++) c = (c >> 1) ^ ((c[0] ^ b[i]) ? 8'h8c : 8'h00);
    return c;
  endfunction

  task complete_run;
    if (miscompares == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // A hung slot ends the run at once
  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
    if (m.hang) begin
      miscompares++;
      complete_run();
    end
  endtask

  // every command starts from a bus reset and a selection
  task automatic head(logic [7:0] cmd, logic [7:0] lo, output logic [7:0] c);
    m.strobe(0);
    m.strobe(1);
    m.put(cmd);
    m.put(lo);
    m.put(8'h00);
    c = crc8(crc8(crc8(8'h00, cmd), lo), 8'h00);
  endtask

  // Read from start to field end, CRC at field or page ends
  task automatic s_rd(logic [7:0] cmd, int start);
    logic [7:0] c, d, e;
    int last;
    last = (cmd == 8'haa) ? 7 : 127;
    head(cmd, start[7:0], c);
    m.get(d);
    check("command crc", d, c);
    c = 8'h00;
    for (int a = start; a <= last; a++) begin
      e = (cmd == 8'haa) ? stat[a] : mem[a];
      m.get(d);
      check("data byte", d, e);
      c = crc8(c, e);
      if (a == last || (cmd == 8'hc3 && a % 32 == 31)) begin
        m.get(d);
        check("field crc", d, c);
        c = 8'h00;
      end
    end
    m.get(d);
    check("trailing ones", d, 8'hff);
  endtask

  // Program n bytes from ad, data stepping down by 11h
  task automatic s_wr(logic [7:0] cmd, logic [7:0] ad, logic [7:0] dv,
                      int n, bit prot);
    logic [7:0] c, d, e;
    head(cmd, ad, c);
    for (int i = 0; i < n; i++) begin
      m.put(dv);
      c = crc8(c, dv);
      m.get(d);
      check("write crc", d, c);
      m.pulse(d === c);
      e = (cmd == 8'h55) ? stat[ad[2:0]] & dv : mem[ad] & (prot ? 8'hff : dv);
      m.get(d);
      check("verify byte", d, e);
      if (cmd == 8'h55) stat[ad[2:0]] = e;
      else mem[ad] = e;
      ad++;
      c = ad;
      dv = dv - 8'h11;
    end
  endtask

  // Abort mid-read, or an unsupported command
  task automatic s_abort(logic [7:0] cmd);
    logic [7:0] c, d;
    head(cmd, 8'h00, c);
    m.get(d);
    check("command crc", d, (cmd == 8'h33) ? 8'hff : c);
    m.get(d);
    if (cmd == 8'h33) check("unknown command", d, 8'hff);
    else check("data byte", d, mem[0]);
    // Busy is sampled off the launching edge
    @(negedge mclk);
    check("busy in command", busy, 8'h01);
    m.strobe(0);
    @(negedge mclk);
    check("busy after abort", busy, 8'h00);
    m.get(d);
    check("after abort", d, 8'hff);
  endtask

  // Main sequence
  initial begin
    foreach (mem[i]) mem[i] = 8'hff;
    foreach (stat[i]) stat[i] = (i == 7) ? 8'h00 : 8'hff;
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    s_wr(8'h0f, 8'h1f, 8'ha5, 2, 0);
    s_wr(8'h0f, 8'h1f, 8'h5a, 1, 0);
    s_wr(8'h55, 8'h00, 8'hfe, 1, 0);
    s_wr(8'h0f, 8'h05, 8'h00, 1, 1);
    s_rd(8'hc3, 'h1e);
    s_rd(8'hf0, 'h7e);
    s_rd(8'haa, 'h05);
    s_abort(8'hf0);
    s_abort(8'h33);
    complete_run();
  end
endmodule // emce_engine_tb
